// ### fp_pkg.sv
// constants, types and register map of the front panel selector
package fp_pkg;
    // timing
    localparam int CLK_MHZ = 250; // system clock rate in mhz
    localparam int HOLD_MS = 4000; // long press threshold in ms
    localparam int DEB_MS = 10; // button and knob settle time in ms
    localparam int BLINK_MS = 250; // led blink half period in ms
    localparam int STEP_MS = 1000; // dimm display step in ms
    localparam int CYC_PER_MS = CLK_MHZ * 1000; // cycles in one ms
    localparam logic [31:0] HOLD_CYC = 32'(HOLD_MS * CYC_PER_MS); // long press cycles
    localparam logic [31:0] DEB_CYC = 32'(DEB_MS * CYC_PER_MS); // settle cycles
    localparam logic [31:0] BLINK_CYC = 32'(BLINK_MS * CYC_PER_MS); // blink half period cycles
    localparam logic [31:0] STEP_CYC = 32'(STEP_MS * CYC_PER_MS); // display step cycles

    // selection codes
    localparam int NSRV = 4; // server slots
    localparam logic [2:0] SEL_BMC = 3'h4; // knob code of the management controller
    localparam int HP_BMC = 4; // hot-plug bit of the management controller

    // register map, byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00; // control
    localparam logic [7:0] OFS_POST = 8'h04; // post code
    localparam logic [7:0] OFS_DUTY = 8'h08; // fan duty
    localparam logic [7:0] OFS_SEQ = 8'h0C; // dimm sequence entry write
    localparam logic [7:0] OFS_STAT = 8'h10; // status
    localparam logic [7:0] OFS_TACH0 = 8'h14; // fan 0 speed feedback count
    localparam logic [7:0] OFS_TACH1 = 8'h18; // fan 1 speed feedback count

    // fields
    localparam int CTRL_FAN_BIT = 0; // management took fan control
    localparam int CTRL_LOOP_BIT = 1; // dimm sequence display on
    localparam int DUTY1_LSB = 8; // second fan duty position
    localparam int SEQ_IDX_LSB = 8; // sequence entry index position
    localparam int STAT_SEL_LSB = 0; // selection code position
    localparam int STAT_PWR_LSB = 4; // server power states position
    localparam int STAT_DBG_BIT = 8; // debug card present
    localparam int STAT_CON_BIT = 9; // local console chosen

    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0; // fans at full, no loop
    localparam logic [7:0] POST_RST = 8'h00; // post display blank code
    localparam logic [7:0] DUTY_RST = 8'hFF; // fan duty after reset

    // register bus request
    typedef struct packed {
        logic [7:0] addr; // byte address
        logic [31:0] wdata; // write data
        logic we; // write strobe
        logic re; // read strobe
    } reg_req_t;

    // power button states
    typedef enum logic [1:0] {
        PB_IDLE = 2'b00,
        PB_PRESS = 2'b01,
        PB_HELD = 2'b10
    } pb_state_t;
endpackage

// ### seq_mem.sv
// small code store for the repeating post display sequence
`timescale 1ns/1ps
module seq_mem #(
    parameter int WIDTH = 8, // bits per entry
    parameter int DEPTH = 4 // entries
) (
    input wire logic clk_i, // system clock
    input wire logic wr_en_i, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i, // write entry
    input wire logic [WIDTH-1:0] wr_data_i, // write value
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i, // read entry
    output logic [WIDTH-1:0] rd_data_o // registered read value
);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage array

    // write port and registered read port
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule

// ### fp_selector.sv
// front panel selector: knob, buttons, leds, post display, console and fans
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fp_selector #(
    parameter logic [31:0] HOLD_CYC = fp_pkg::HOLD_CYC, // long press cycles
    parameter logic [31:0] DEB_CYC = fp_pkg::DEB_CYC, // settle cycles
    parameter logic [31:0] BLINK_CYC = fp_pkg::BLINK_CYC, // blink half period cycles
    parameter logic [31:0] STEP_CYC = fp_pkg::STEP_CYC // display step cycles
) (
    input wire logic clk_i, // system clock
    input wire logic arst_n_i, // async reset, low active
    input wire fp_pkg::reg_req_t reg_req_i, // register bus request
    output logic [31:0] rd_data_o, // read data, cycle after read strobe
    input wire logic [2:0] knob_i, // selector knob code
    input wire logic pwr_btn_n_i, // power button, low pressed
    input wire logic rst_btn_n_i, // reset button, low pressed
    input wire logic dbg_rst_n_i, // debug card reset, low pressed
    input wire logic dbg_uart_sel_i, // debug card console channel select
    input wire logic dbg_present_i, // debug card plugged
    input wire logic [3:0] srv_pwr_on_i, // server powered per slot
    input wire logic [1:0] fan_speed_feedback_i, // fan tach pulses
    output logic [3:0] srv_pwr_evt_o, // power event pulse per server
    output logic [3:0] srv_hard_off_o, // forced off pulse per server
    output logic [3:0] srv_hard_rst_o, // hard reset pulse per server
    output logic [2:0] dbg_route_o, // debug card target code
    output logic usb_en_o, // front usb connected
    output logic [1:0] usb_sel_o, // front usb server
    output logic [1:0] vga_sel_o, // video mux server
    output logic [4:0] hotplug_o, // hot-plug pulse, servers and management
    output logic [3:0] led_ident_o, // blue selection leds
    output logic [3:0] led_pwr_o, // power status leds
    output logic [3:0] post_low_o, // post code low digit
    output logic [3:0] post_high_o, // post code high digit
    output logic console_local_o, // console to card serial port
    output logic [1:0] fan_pwm_o // fan speed control
);
    localparam int PIN_W = 14; // synchronised pin count
    localparam int DEB_W = 6; // debounced bit count

    logic [PIN_W-1:0] pin_raw; // pins, buttons made active high
    logic [PIN_W-1:0] sync1_q; // first sync stage
    logic [PIN_W-1:0] pin_s; // second sync stage
    logic [DEB_W-1:0] deb_q; // debounced knob and buttons
    logic [DEB_W-1:0] deb_d;
    logic [31:0] deb_cnt_q [DEB_W]; // settle counters
    logic [31:0] deb_cnt_d [DEB_W];
    logic [2:0] knob_db; // settled knob
    logic pwr_db, rst_db, dbgrst_db; // settled buttons
    logic [3:0] pwr_on_s; // synced power states
    logic [1:0] tach_s; // synced fan feedback

    assign pin_raw = {fan_speed_feedback_i, srv_pwr_on_i, dbg_present_i, dbg_uart_sel_i,
                      ~dbg_rst_n_i, ~rst_btn_n_i, ~pwr_btn_n_i, knob_i};
    assign knob_db = deb_q[2:0];
    assign pwr_db = deb_q[3];
    assign rst_db = deb_q[4];
    assign dbgrst_db = deb_q[5];
    assign pwr_on_s = pin_s[11:8];
    assign tach_s = pin_s[13:12];

    // two flop synchroniser on every pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= '0;
            pin_s <= '0;
        end else begin
            sync1_q <= pin_raw;
            pin_s <= sync1_q;
        end
    end

    // per bit debounce: change only after a full quiet period
    for (genvar i = 0; i < DEB_W; i++) begin : g_deb
        always_comb begin
            deb_d[i] = deb_q[i];
            deb_cnt_d[i] = 32'h0;
            if (pin_s[i] != deb_q[i]) begin
                if (deb_cnt_q[i] == DEB_CYC - 32'h1) begin
                    deb_d[i] = pin_s[i];
                end else begin
                    deb_cnt_d[i] = deb_cnt_q[i] + 32'h1;
                end
            end
        end
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                deb_q[i] <= 1'b0;
                deb_cnt_q[i] <= 32'h0;
            end else begin
                deb_q[i] <= deb_d[i];
                deb_cnt_q[i] <= deb_cnt_d[i];
            end
        end
    end

    // selection, video mux and hot-plug
    logic [2:0] sel_q, sel_d; // current target code
    logic [1:0] vga_q, vga_d; // video mux position
    logic [4:0] hp_d; // hot-plug next
    logic srv_sel; // a server is selected

    assign srv_sel = (sel_q != fp_pkg::SEL_BMC);

    always_comb begin
        sel_d = (knob_db < fp_pkg::SEL_BMC) ? knob_db : fp_pkg::SEL_BMC; // spare codes mean management
        vga_d = (sel_d != fp_pkg::SEL_BMC) ? sel_d[1:0] : vga_q;
        hp_d = 5'h00;
        if (vga_d != vga_q) begin
            hp_d[fp_pkg::HP_BMC] = 1'b1;
            hp_d[vga_q] = 1'b1; // old server
            hp_d[vga_d] = 1'b1; // new server
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_q <= fp_pkg::SEL_BMC;
            vga_q <= 2'h0;
            hotplug_o <= 5'h00;
        end else begin
            sel_q <= sel_d;
            vga_q <= vga_d;
            hotplug_o <= hp_d;
        end
    end
    assign vga_sel_o = vga_q;

    // power button press timer
    fp_pkg::pb_state_t pb_q, pb_d; // button state
    logic [31:0] hold_cnt_q, hold_cnt_d; // press duration
    logic [3:0] evt_d, off_d; // power event and forced off

    always_comb begin
        pb_d = pb_q;
        hold_cnt_d = hold_cnt_q;
        evt_d = 4'h0;
        off_d = 4'h0;
        case (pb_q)
            fp_pkg::PB_IDLE: begin
                hold_cnt_d = 32'h0;
                if (pwr_db) begin
                    pb_d = fp_pkg::PB_PRESS;
                end
            end
            fp_pkg::PB_PRESS: begin
                if (!pwr_db) begin
                    pb_d = fp_pkg::PB_IDLE;
                    if (srv_sel) begin
                        evt_d[sel_q[1:0]] = 1'b1;
                    end
                end else if (hold_cnt_q == HOLD_CYC - 32'h1) begin
                    pb_d = fp_pkg::PB_HELD;
                    if (srv_sel && pwr_on_s[sel_q[1:0]]) begin
                        off_d[sel_q[1:0]] = 1'b1;
                    end
                end else begin
                    hold_cnt_d = hold_cnt_q + 32'h1;
                end
            end
            fp_pkg::PB_HELD: begin
                if (!pwr_db) begin
                    pb_d = fp_pkg::PB_IDLE;
                end
            end
            default: pb_d = fp_pkg::PB_IDLE;
        endcase
    end

    // reset requests from front button and debug card
    logic rst_prev_q, dbg_prev_q; // previous settled levels
    logic rst_evt; // a new press on either source
    logic [3:0] rst_d; // hard reset next

    always_comb begin
        rst_evt = (rst_db && !rst_prev_q) || (dbgrst_db && !dbg_prev_q);
        rst_d = 4'h0;
        if (rst_evt && srv_sel && pwr_on_s[sel_q[1:0]]) begin
            rst_d[sel_q[1:0]] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pb_q <= fp_pkg::PB_IDLE;
            hold_cnt_q <= 32'h0;
            rst_prev_q <= 1'b0;
            dbg_prev_q <= 1'b0;
            srv_pwr_evt_o <= 4'h0;
            srv_hard_off_o <= 4'h0;
            srv_hard_rst_o <= 4'h0;
        end else begin
            pb_q <= pb_d;
            hold_cnt_q <= hold_cnt_d;
            rst_prev_q <= rst_db;
            dbg_prev_q <= dbgrst_db;
            srv_pwr_evt_o <= evt_d;
            srv_hard_off_o <= off_d;
            srv_hard_rst_o <= rst_d;
        end
    end

    // blink and one second timers, dimm sequence index
    logic [31:0] blink_cnt_q, blink_cnt_d, step_cnt_q, step_cnt_d; // timers
    logic blink_q, blink_d, step_tick; // blink phase, step pulse
    logic [1:0] seq_idx_q, seq_idx_d; // sequence entry shown
    logic [1:0] ctrl_q; // control register

    always_comb begin
        blink_cnt_d = blink_cnt_q + 32'h1;
        blink_d = blink_q;
        if (blink_cnt_q == BLINK_CYC - 32'h1) begin
            blink_cnt_d = 32'h0;
            blink_d = !blink_q;
        end
        step_tick = (step_cnt_q == STEP_CYC - 32'h1);
        step_cnt_d = step_tick ? 32'h0 : step_cnt_q + 32'h1;
        seq_idx_d = seq_idx_q;
        if (!ctrl_q[fp_pkg::CTRL_LOOP_BIT]) begin
            seq_idx_d = 2'h0;
        end else if (step_tick) begin
            seq_idx_d = seq_idx_q + 2'h1; // wraps
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
            step_cnt_q <= 32'h0;
            seq_idx_q <= 2'h0;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
            step_cnt_q <= step_cnt_d;
            seq_idx_q <= seq_idx_d;
        end
    end

    // register file
    logic [1:0] ctrl_d; // control next
    logic [7:0] post_q, post_d; // post code from management
    logic [15:0] duty_q, duty_d; // fan duties
    logic [15:0] tach_q [2]; // latched fan speed counts
    logic [31:0] rd_d; // read data next
    logic seq_we; // sequence entry write
    logic [7:0] seq_code; // sequence code read out

    assign seq_we = reg_req_i.we && (reg_req_i.addr == fp_pkg::OFS_SEQ);

    seq_mem #(
        .WIDTH(8),
        .DEPTH(4)
    ) u_seq_mem (
        .clk_i(clk_i),
        .wr_en_i(seq_we),
        .wr_addr_i(reg_req_i.wdata[fp_pkg::SEQ_IDX_LSB +: 2]),
        .wr_data_i(reg_req_i.wdata[7:0]),
        .rd_addr_i(seq_idx_q),
        .rd_data_o(seq_code)
    );

    always_comb begin
        ctrl_d = ctrl_q;
        post_d = post_q;
        duty_d = duty_q;
        rd_d = 32'h0;
        if (reg_req_i.we) begin
            case (reg_req_i.addr)
                fp_pkg::OFS_CTRL: ctrl_d = reg_req_i.wdata[1:0];
                fp_pkg::OFS_POST: post_d = reg_req_i.wdata[7:0];
                fp_pkg::OFS_DUTY: duty_d = reg_req_i.wdata[15:0];
                default: ; // sequence entry goes to u_seq_mem; read-only or unmapped: ignored
            endcase
        end
        if (reg_req_i.re) begin
            case (reg_req_i.addr)
                fp_pkg::OFS_CTRL: rd_d[1:0] = ctrl_q;
                fp_pkg::OFS_POST: rd_d[7:0] = post_q;
                fp_pkg::OFS_DUTY: rd_d[15:0] = duty_q;
                fp_pkg::OFS_STAT: begin
                    rd_d[fp_pkg::STAT_SEL_LSB +: 3] = sel_q;
                    rd_d[fp_pkg::STAT_PWR_LSB +: 4] = pwr_on_s;
                    rd_d[fp_pkg::STAT_DBG_BIT] = pin_s[7];
                    rd_d[fp_pkg::STAT_CON_BIT] = console_local_o;
                end
                fp_pkg::OFS_TACH0: rd_d[15:0] = tach_q[0];
                fp_pkg::OFS_TACH1: rd_d[15:0] = tach_q[1];
                default: rd_d = 32'h0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= fp_pkg::CTRL_RST;
            post_q <= fp_pkg::POST_RST;
            duty_q <= {fp_pkg::DUTY_RST, fp_pkg::DUTY_RST};
            rd_data_o <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            post_q <= post_d;
            duty_q <= duty_d;
            rd_data_o <= rd_d;
        end
    end

    // fans: pwm and feedback edge count per one second window
    logic [7:0] pwm_cnt_q; // shared pwm ramp
    for (genvar f = 0; f < 2; f++) begin : g_fan
        logic [15:0] edge_cnt_q, edge_cnt_d, tach_d; // pulses this window
        logic prev_q, pwm_d; // previous feedback level, pwm next
        always_comb begin
            pwm_d = !ctrl_q[fp_pkg::CTRL_FAN_BIT] ||
                    (pwm_cnt_q < duty_q[f * fp_pkg::DUTY1_LSB +: 8]);
            edge_cnt_d = edge_cnt_q + 16'((tach_s[f] && !prev_q) ? 1 : 0);
            tach_d = tach_q[f];
            if (step_tick) begin
                tach_d = edge_cnt_d;
                edge_cnt_d = 16'h0;
            end
        end
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                edge_cnt_q <= 16'h0;
                prev_q <= 1'b0;
                tach_q[f] <= 16'h0;
                fan_pwm_o[f] <= 1'b1;
            end else begin
                edge_cnt_q <= edge_cnt_d;
                prev_q <= tach_s[f];
                tach_q[f] <= tach_d;
                fan_pwm_o[f] <= pwm_d;
            end
        end
    end

    // routing, leds, display and console outputs
    logic [3:0] ident_d; // selection leds next
    logic [7:0] disp; // code shown

    always_comb begin
        ident_d = srv_sel ? (4'h1 << sel_q[1:0]) : 4'hF;
        ident_d = blink_q ? ident_d : 4'h0;
        disp = ctrl_q[fp_pkg::CTRL_LOOP_BIT] ? seq_code : post_q;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwm_cnt_q <= 8'h00;
            dbg_route_o <= fp_pkg::SEL_BMC;
            usb_en_o <= 1'b0;
            usb_sel_o <= 2'h0;
            led_ident_o <= 4'h0;
            led_pwr_o <= 4'h0;
            post_low_o <= 4'h0;
            post_high_o <= 4'h0;
            console_local_o <= 1'b0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
            dbg_route_o <= sel_q;
            usb_en_o <= srv_sel;
            usb_sel_o <= srv_sel ? sel_q[1:0] : usb_sel_o;
            led_ident_o <= ident_d;
            led_pwr_o <= pwr_on_s;
            post_low_o <= disp[3:0];
            post_high_o <= disp[7:4];
            console_local_o <= pin_s[7] && pin_s[6];
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_bmc_sel;
        sel_q == fp_pkg::SEL_BMC;
    endsequence
    sequence s_short_rel;
        pb_q == fp_pkg::PB_PRESS && !pwr_db && srv_sel;
    endsequence

    property p_usb_bmc;
        s_bmc_sel |=> !usb_en_o && srv_pwr_evt_o == 4'h0 && srv_hard_off_o == 4'h0 && srv_hard_rst_o == 4'h0;
    endproperty
    a_usb_bmc: assert property (p_usb_bmc) else $error("management got button or usb");
    property p_route;
        srv_sel |=> usb_en_o && usb_sel_o == $past(sel_q[1:0]) && dbg_route_o == $past(sel_q);
    endproperty
    a_route: assert property (p_route) else $error("server routing wrong");
    property p_blink_one;
        srv_sel |=> (led_ident_o & ~(4'h1 << $past(sel_q[1:0]))) == 4'h0;
    endproperty
    a_blink_one: assert property (p_blink_one) else $error("wrong led blinks");
    property p_blink_all;
        s_bmc_sel ##1 s_bmc_sel |-> led_ident_o == {4{$past(blink_q)}};
    endproperty
    a_blink_all: assert property (p_blink_all) else $error("leds not blinking together");
    property p_short;
        s_short_rel |=> srv_pwr_evt_o == (4'h1 << $past(sel_q[1:0])) ##1 srv_pwr_evt_o == 4'h0;
    endproperty
    a_short: assert property (p_short) else $error("short press lost");
    property p_long;
        pb_q == fp_pkg::PB_PRESS && pwr_db && hold_cnt_q == HOLD_CYC - 32'h1 && srv_sel && pwr_on_s[sel_q[1:0]]
            |=> srv_hard_off_o == (4'h1 << $past(sel_q[1:0])) && pb_q == fp_pkg::PB_HELD;
    endproperty
    a_long: assert property (p_long) else $error("long press did not force off");
    property p_rst;
        rst_evt && srv_sel && pwr_on_s[sel_q[1:0]] |=> srv_hard_rst_o == (4'h1 << $past(sel_q[1:0]));
    endproperty
    a_rst: assert property (p_rst) else $error("reset press lost");
    property p_dbg_rst;
        dbgrst_db && !dbg_prev_q && srv_sel && pwr_on_s[sel_q[1:0]] |=> srv_hard_rst_o != 4'h0;
    endproperty
    a_dbg_rst: assert property (p_dbg_rst) else $error("card reset lost");
    property p_post;
        $changed(disp) |=> post_low_o == $past(disp[3:0]) && post_high_o == $past(disp[7:4]);
    endproperty
    a_post: assert property (p_post) else $error("post lines wrong");
    property p_vga;
        srv_sel |-> vga_sel_o == sel_q[1:0];
    endproperty
    a_vga: assert property (p_vga) else $error("video mux not following");
    property p_hotplug;
        $changed(vga_sel_o) |-> hotplug_o[fp_pkg::HP_BMC] && hotplug_o[vga_sel_o] && hotplug_o[$past(vga_sel_o)];
    endproperty
    a_hotplug: assert property (p_hotplug) else $error("hot-plug not signalled");
    property p_fan_full;
        !ctrl_q[fp_pkg::CTRL_FAN_BIT] |=> fan_pwm_o == 2'h3;
    endproperty
    a_fan_full: assert property (p_fan_full) else $error("fans not at full");
    property p_console;
        !pin_s[7] |=> !console_local_o;
    endproperty
    a_console: assert property (p_console) else $error("console left network");
    property p_deb;
        $changed(pwr_db) |-> $past(deb_cnt_q[3]) == DEB_CYC - 32'h1;
    endproperty
    a_deb: assert property (p_deb) else $error("button changed before settling");
    property p_led_pwr;
        ##1 1'b1 |-> led_pwr_o == $past(pwr_on_s);
    endproperty
    a_led_pwr: assert property (p_led_pwr) else $error("power led mismatch");
endmodule

// ### fp_srv_model.sv
// behavioural server cards behind the selector
`timescale 1ns/1ps
module fp_srv_model (
    input wire logic clk_i, // system clock
    input wire logic arst_n_i, // async reset, low active
    input wire logic [3:0] evt_i, // power event pulses
    input wire logic [3:0] off_i, // forced off pulses
    input wire logic [3:0] rst_i, // hard reset pulses
    output logic [3:0] on_o, // powered state
    output logic [3:0] rst_seen_o // toggles on each reset taken
);
    // event powers on, forced off powers down, reset only when on
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            on_o <= 4'h0;
            rst_seen_o <= 4'h0;
        end else begin
            on_o <= (on_o | evt_i) & ~off_i;
            rst_seen_o <= rst_seen_o ^ (rst_i & on_o);
        end
    end
endmodule

// ### front_panel_selector_post_display_bench.sv
// self-checking bench of the front panel selector
`timescale 1ns/1ps
module front_panel_selector_post_display_bench;
    logic clk_i, arst_n_i, pwr_n, rst_n, drst_n, usel, pres; // pin drives
    logic [2:0] knob, route; // knob and card target
    logic [1:0] s, usb_sel, vga, pwm; // chosen server and muxes
    logic [1:0] tach = 2'h0; // fan feedback
    logic [3:0] evt, off, hrst, on, seen, lpw, plo, phi, lid; // pulses and states
    logic [4:0] hp; // hot-plug pulses
    logic [4:0] hs; // hot-plug pulses seen in one selection step
    logic [31:0] rd, rnd = 32'h1; // read data, random state
    logic usb_en, con; // usb connect, console
    logic [7:0] code [4] = '{8'h00, 8'hA1, 8'h5E, 8'h3C}; // failure sequence
    fp_pkg::reg_req_t req; // bus request
    int err_total, compares, i, n; // counts
    fp_selector #(.HOLD_CYC(32'h28), .DEB_CYC(32'h3), .BLINK_CYC(32'h4), .STEP_CYC(32'h10)) dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(req), .rd_data_o(rd), .knob_i(knob), .pwr_btn_n_i(pwr_n),
        .rst_btn_n_i(rst_n), .dbg_rst_n_i(drst_n), .dbg_uart_sel_i(usel), .dbg_present_i(pres), .srv_pwr_on_i(on),
        .fan_speed_feedback_i(tach), .srv_pwr_evt_o(evt), .srv_hard_off_o(off), .srv_hard_rst_o(hrst),
        .dbg_route_o(route), .usb_en_o(usb_en), .usb_sel_o(usb_sel), .vga_sel_o(vga), .hotplug_o(hp),
        .led_ident_o(lid), .led_pwr_o(lpw), .post_low_o(plo), .post_high_o(phi), .console_local_o(con),
        .fan_pwm_o(pwm));
    fp_srv_model srv (.clk_i(clk_i), .arst_n_i(arst_n_i), .evt_i(evt), .off_i(off), .rst_i(hrst), .on_o(on),
        .rst_seen_o(seen));
    function automatic logic [31:0] xs(input logic [31:0] v); // xorshift step
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp); // compare one value
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results(); // verdict and end
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic pause(input int n); // idle cycles
        repeat (n) @(posedge clk_i);
    endtask
    task automatic press(input int b, input int n); // hold one button low n cycles
        if (b == 0) pwr_n <= 1'b0;
        else if (b == 1) rst_n <= 1'b0;
        else drst_n <= 1'b0;
        pause(n);
        {pwr_n, rst_n, drst_n} <= 3'h7;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); // one bus write
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req <= '{a, d, 1'b0, 1'b0};
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e); // one bus read, data checked next cycle
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        req <= '{a, 32'h0, 1'b0, 1'b0};
        @(negedge clk_i);
        chk(rd, e);
        @(posedge clk_i);
    endtask
    task automatic wait_val(input logic [7:0] e, input bit post); // bounded wait for code or power state
        int n;
        for (n = 0; n < 300 && (post ? {phi, plo} : {4'h0, on}) !== e; n++) @(posedge clk_i);
        chk(post ? {phi, plo} : {4'h0, on}, e);
        if (n == 300) results();
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // random feedback pulses on the fan inputs
    always @(posedge clk_i) begin
        rnd <= xs(rnd);
        tach <= rnd[1:0];
    end
    initial begin
        {arst_n_i, pwr_n, rst_n, drst_n, usel, pres, knob, req} = {1'b0, 3'h7, 2'h0, 3'h4, 42'h0};
        pause(3);
        arst_n_i <= 1'b1;
        @(negedge clk_i);
        chk({pwm, route, usb_en}, 6'h38);
        @(posedge clk_i);
        for (i = 0; i < 5; i++) begin // every server, then management
            knob <= 3'(i);
            hs = 5'h00;
            n = 0;
            repeat (20) @(negedge clk_i) hs = hs | hp;
            repeat (16) begin // count lit cycles of the selection leds
                @(negedge clk_i);
                if (lid != 4'h0) begin
                    n++;
                    chk(lid, i < 4 ? 32'h1 << i : 32'hF);
                end
            end
            chk(n, 32'h8);
            chk(hs, i % 4 == 0 ? 32'h0 : 32'h10 | (32'h3 << (i - 1)));
            chk({route, usb_en, usb_sel, vga}, i < 4 ? {3'(i), 1'b1, 2'(i), 2'(i)} : {8'h8F});
            @(posedge clk_i);
        end
        press(0, 10);
        pause(30);
        chk(on, 4'h0);
        $display("test selection done");
        s = rnd[1:0];
        knob <= {1'b0, s};
        pause(20);
        press(0, 10);
        wait_val(8'h1 << s, 1'b0);
        pause(5);
        chk(lpw, on);
        press(1, 10);
        pause(20);
        chk(seen, 4'h1 << s);
        press(2, 10);
        pause(20);
        chk(seen, 4'h0);
        press(0, 80);
        pause(30);
        chk(on, 4'h0);
        $display("test buttons done");
        {pres, usel} <= 2'h3;
        pause(10);
        chk(con, 1'b1);
        pres <= 1'b0;
        pause(10);
        chk(con, 1'b0);
        wr(fp_pkg::OFS_POST, 32'h5A);
        pause(4);
        chk({phi, plo}, 8'h5A);
        rd_chk(8'h1C, 32'h0);
        rd_chk(fp_pkg::OFS_POST, 32'h5A);
        rd_chk(fp_pkg::OFS_STAT, 32'(s));
        wr(fp_pkg::OFS_DUTY, 32'hFF00);
        wr(fp_pkg::OFS_CTRL, 32'h1);
        rd_chk(fp_pkg::OFS_DUTY, 32'hFF00);
        chk(pwm[0], 1'b0);
        for (i = 0; i < 4; i++) wr(fp_pkg::OFS_SEQ, {22'h0, 2'(i), code[i]});
        wr(fp_pkg::OFS_CTRL, 32'h2);
        for (i = 1; i < 6; i++) wait_val(code[i % 4], 1'b1);
        chk(pwm, 2'h3);
        $display("test display done");
        results();
    end
endmodule
